// [core/adf_pkg.sv]
// Shared constants and types for the serial converter front end and its bus master.
// Notes on behaviour
// RULE1: Master sends address first after every start.
// RULE2: Answer only fixed part plus strap pins.
// RULE3: Address bit 0 chooses write or read.
// RULE4: Byte after write address loads control register.
// RULE5: Upper nibble output/config, lower nibble channel.
// RULE6: Four inputs, single-ended or differential configs.
// RULE7: Auto-increment advances channel after each conversion.
// RULE8: Nonexistent channel becomes highest available channel.
// RULE9: Auto-increment wraps past highest channel to zero.
// RULE10: Bit 6 enables output, keeps oscillator running.
// RULE11: Master sets output enable with auto-increment.
// RULE12: Master may clear output enable to save power.
// RULE13: Master writes zero to both nibble MSBs.
// RULE14: Reset clears every control register bit.
// RULE15: After reset converter, oscillator off, output floating.
// RULE16: Bits 1:0 channel, 2 auto, 5:4 config.
// RULE17: Write ending after address keeps control unchanged.
// RULE18: Third written byte becomes held output code.
// RULE19: Read address ack trailing edge starts conversion.
// RULE20: First read byte after reset is 80h.
// RULE21: Master ends write with stop or start.
`default_nettype none
package adf_pkg;
   localparam int          ADF_BYTE_W         = 8;
   // Fixed address part; default value is arbitrary.
   localparam logic [3:0]  ADF_FIXED_ADDR_DEF = 4'hA;
   // Control register layout and reset values.
   localparam int          ADF_CH_LSB         = 0;
   localparam int          ADF_AUTO_BIT       = 2;
   localparam int          ADF_CFG_LSB        = 4;
   localparam int          ADF_AOE_BIT        = 6;
   localparam logic [7:0]  ADF_RSVD_MASK      = 8'h88;
   localparam logic [7:0]  ADF_CTRL_RESET     = 8'h00;
   localparam logic [7:0]  ADF_DAC_RESET      = 8'h00;
   localparam logic [7:0]  ADF_ADC_RESET      = 8'h80;
   // Highest channel per input configuration, two bits per entry, config 0 lowest.
   localparam logic [7:0]  ADF_MAX_CH_TABLE   = 8'h6B;
   // Master command port map and fields.
   localparam logic [1:0]  ADF_REG_CMD        = 2'h0;
   localparam logic [1:0]  ADF_REG_TXD        = 2'h1;
   localparam logic [1:0]  ADF_REG_RXD        = 2'h2;
   localparam logic [1:0]  ADF_REG_STAT       = 2'h3;
   localparam int          ADF_CMD_START      = 0;
   localparam int          ADF_CMD_STOP       = 1;
   localparam int          ADF_CMD_READ       = 2;
   localparam int          ADF_CMD_NACK       = 3;
   localparam int          ADF_CMD_CTRL       = 4;
   localparam int          ADF_STAT_BUSY      = 0;
   localparam int          ADF_STAT_ACK       = 1;
   // Bus clock timing, four quarter phases per bit.
   localparam int          ADF_SCL_PERIOD_NS  = 800;
   localparam int          ADF_CLK_PERIOD_NS  = 100;
   localparam logic [7:0]  ADF_QTR_CYC        = 8'(ADF_SCL_PERIOD_NS / (4 * ADF_CLK_PERIOD_NS));
   localparam logic [3:0]  ADF_LAST_BIT       = 4'h8;
   typedef enum logic [2:0] {ADF_D_IDLE, ADF_D_ADDR, ADF_D_ADDR_ACK, ADF_D_WR_BYTE,
                             ADF_D_WR_ACK, ADF_D_RD_BYTE, ADF_D_RD_ACK} adf_dev_state_t;
   typedef enum logic [1:0] {ADF_H_IDLE, ADF_H_START, ADF_H_BITS, ADF_H_STOP} adf_host_state_t;
endpackage
`default_nettype wire

// [core/adf_link_if.sv]
// Two-wire link between the bus master and the converter front end.
`timescale 1ns/100ps
`default_nettype none
interface adf_link_if;
   logic      host_scl_oe_n;
   logic      host_scl_out;
   logic      host_sda_oe_n;
   logic      host_sda_out;
   logic      dev_sda_oe_n;
   logic      dev_sda_out;
   wire logic scl;
   wire logic sda;

   // Open-drain wired AND with pull-up: a line is low only while someone drives it low.
   assign scl = host_scl_oe_n | host_scl_out;
   assign sda = (host_sda_oe_n | host_sda_out) & (dev_sda_oe_n | dev_sda_out);

   modport host (output host_scl_oe_n, output host_scl_out, output host_sda_oe_n,
                 output host_sda_out, input scl, input sda);
   modport dev (output dev_sda_oe_n, output dev_sda_out, input scl, input sda);
endinterface
`default_nettype wire

// [core/adf_sync.sv]
// Two-stage synchroniser for levels arriving from outside the system clock.
`timescale 1ns/100ps
`default_nettype none
module adf_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk_sys,
   input  wire logic             reset,
   input  wire logic             clk_en,
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] meta;

   // Resets to ones so an idle bus is not mistaken for a start after reset.
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         meta <= '1;
         dout <= '1;
      end
      else if (clk_en)
      begin
         meta <= din;
         dout <= meta;
      end
   end
endmodule
`default_nettype wire

// [core/adf_dev_end.sv]
// Device end: serial slave, control register, output code and conversion sequencing.
//
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/100ps
`default_nettype none
module adf_dev_end
   import adf_pkg::*;
#(
   parameter logic [3:0] FIXED_ADDR = adf_pkg::ADF_FIXED_ADDR_DEF
) (
   input  wire logic                             clk_sys,
   input  wire logic                             reset,
   input  wire logic                             clk_en,
   adf_link_if.dev                               link,
   input  wire logic                             addr_strap_0,
   input  wire logic                             addr_strap_1,
   input  wire logic                             addr_strap_2,
   input  wire logic                             clock_source_select,
   input  wire logic [adf_pkg::ADF_BYTE_W-1:0]   adc_result,
   input  wire logic                             adc_done,
   output logic      [adf_pkg::ADF_BYTE_W-1:0]   function_control,
   output logic      [adf_pkg::ADF_BYTE_W-1:0]   dac_code,
   output logic                                  analog_out_enable,
   output logic                                  osc_enable,
   output logic                                  osc_out_enable,
   output logic                                  adc_start,
   output logic      [1:0]                       adc_channel,
   output logic      [1:0]                       adc_config
);
   import adf_pkg::*;

   adf_dev_state_t state;
   logic [4:0]     sync_q;
   logic           scl_s;
   logic           sda_s;
   logic [2:0]     strap_s;
   logic           scl_d;
   logic           sda_d;
   logic [3:0]     bit_cnt;
   logic [7:0]     shreg;
   logic [7:0]     tx_sh;
   logic [7:0]     adc_data;
   logic           rw;
   logic           mack;
   logic           sda_low;
   logic           got_ctrl;
   logic           conv_busy;

   // Bus lines and straps come from outside this clock and are synchronised first.
   adf_sync #(
      .WIDTH (5)
   ) u_sync (
      .clk_sys (clk_sys),
      .reset   (reset),
      .clk_en  (clk_en),
      .din     ({link.scl, link.sda, addr_strap_2, addr_strap_1, addr_strap_0}),
      .dout    (sync_q)
   );

   // Edge and condition detection on the synchronised lines.
   wire logic scl_rise   = scl_s & ~scl_d;
   wire logic scl_fall   = ~scl_s & scl_d;
   wire logic start_det  = scl_s & scl_d & sda_d & ~sda_s;
   wire logic stop_det   = scl_s & scl_d & ~sda_d & sda_s;
   wire logic byte_full  = scl_fall & (bit_cnt == ADF_LAST_BIT);

   assign scl_s   = sync_q[4];
   assign sda_s   = sync_q[3];
   assign strap_s = sync_q[2:0];

   // Address compare: fixed upper part and the three strap levels.
   wire logic addr_match = (shreg[7:4] == FIXED_ADDR) && (shreg[3:1] == strap_s);  // RULE2

   // Trigger points: end of the ack pulse of a read address or of an acked read byte.
   wire logic rd_trigger = scl_fall & (((state == ADF_D_ADDR_ACK) & rw)  // RULE19
                                      | ((state == ADF_D_RD_ACK) & mack));
   wire logic wr_done    = (state == ADF_D_WR_BYTE) & byte_full;

   // Highest channel for the stored configuration and for the byte being written.
   wire logic [1:0] cfg_cur  = function_control[ADF_CFG_LSB +: 2];           // RULE16
   wire logic [1:0] cfg_new  = shreg[ADF_CFG_LSB +: 2];
   wire logic [1:0] max_cur  = ADF_MAX_CH_TABLE[{cfg_cur, 1'b0} +: 2];      // RULE6
   wire logic [1:0] max_new  = ADF_MAX_CH_TABLE[{cfg_new, 1'b0} +: 2];
   wire logic [1:0] sel_new  = shreg[ADF_CH_LSB +: 2];
   wire logic [1:0] ch_clamp = (sel_new > max_new) ? max_new : sel_new;      // RULE8
   wire logic [1:0] ch_next  = (adc_channel >= max_cur) ? 2'h0 : adc_channel + 2'h1;  // RULE9
   wire logic       auto_inc = function_control[ADF_AUTO_BIT];
   wire logic       aoe      = function_control[ADF_AOE_BIT];                 // RULE10

   // Previous line levels for edge detection.
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end
      else if (clk_en)
      begin
         scl_d <= scl_s;
         sda_d <= sda_s;
      end
   end

   // Serial protocol engine. Start and stop abort any transfer in progress,
   // so a repeated start cleanly ends a write as well.
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         state     <= ADF_D_IDLE;
         bit_cnt   <= 4'h0;
         shreg     <= 8'h00;
         tx_sh     <= 8'h00;
         rw        <= 1'b0;
         mack      <= 1'b0;
         sda_low   <= 1'b0;
         adc_start <= 1'b0;
      end
      else if (clk_en)
      begin
         adc_start <= 1'b0;
         if (start_det)
         begin
            state   <= ADF_D_ADDR;                                           // RULE1
            bit_cnt <= 4'h0;
            sda_low <= 1'b0;
         end
         else if (stop_det)
         begin
            state   <= ADF_D_IDLE;                                           // RULE21
            sda_low <= 1'b0;
         end
         else if (rd_trigger)
         begin
            // Send the stored result while the new conversion runs.
            state     <= ADF_D_RD_BYTE;
            tx_sh     <= adc_data;                                           // RULE20
            sda_low   <= ~adc_data[7];
            bit_cnt   <= 4'h0;
            adc_start <= 1'b1;                                               // RULE19
         end
         else
         begin
            case (state)
               ADF_D_ADDR, ADF_D_WR_BYTE:
               begin
                  if (scl_rise)
                  begin
                     shreg   <= {shreg[6:0], sda_s};
                     bit_cnt <= bit_cnt + 4'h1;
                  end
                  else if (byte_full && state == ADF_D_ADDR)
                  begin
                     rw      <= shreg[0];                                    // RULE3
                     sda_low <= addr_match;
                     state   <= addr_match ? ADF_D_ADDR_ACK : ADF_D_IDLE;    // RULE2
                  end
                  else if (byte_full)
                  begin
                     sda_low <= 1'b1;
                     state   <= ADF_D_WR_ACK;
                  end
               end
               ADF_D_ADDR_ACK, ADF_D_WR_ACK:
               begin
                  // Only a write address or a written byte reaches here on a fall.
                  if (scl_fall)
                  begin
                     sda_low <= 1'b0;
                     bit_cnt <= 4'h0;
                     state   <= ADF_D_WR_BYTE;                               // RULE3
                  end
               end
               ADF_D_RD_BYTE:
               begin
                  if (scl_fall && bit_cnt == 4'h7)
                  begin
                     sda_low <= 1'b0;
                     state   <= ADF_D_RD_ACK;
                  end
                  else if (scl_fall)
                  begin
                     sda_low <= ~tx_sh[6];
                     tx_sh   <= {tx_sh[6:0], 1'b0};
                     bit_cnt <= bit_cnt + 4'h1;
                  end
               end
               ADF_D_RD_ACK:
               begin
                  // A master nack ends the read; the line stays released until stop.
                  if (scl_rise)
                  begin
                     mack <= ~sda_s;
                  end
                  else if (scl_fall)
                  begin
                     state <= ADF_D_IDLE;
                  end
               end
               ADF_D_IDLE:
               begin
                  sda_low <= 1'b0;
               end
               default:
               begin
                  state   <= ADF_D_IDLE;
                  sda_low <= 1'b0;
               end
            endcase
         end
      end
   end

   // Control and output code registers. The first written byte after the address
   // is control, every later one is output code until the transfer ends.
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         function_control <= ADF_CTRL_RESET;                                 // RULE14
         dac_code         <= ADF_DAC_RESET;
         got_ctrl         <= 1'b0;
      end
      else if (clk_en)
      begin
         if (start_det)
         begin
            got_ctrl <= 1'b0;                                                // RULE17
         end
         else if (wr_done && !got_ctrl)
         begin
            function_control <= shreg;                                       // RULE4
            got_ctrl         <= 1'b1;
         end
         else if (wr_done)
         begin
            dac_code <= shreg;                                               // RULE18
         end
      end
   end

   // Conversion result store and channel pointer. A control write in the same
   // cycle as a finished conversion wins, since software asked for that channel.
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         adc_data    <= ADF_ADC_RESET;                                       // RULE20
         adc_channel <= 2'h0;
         conv_busy   <= 1'b0;
      end
      else if (clk_en)
      begin
         if (adc_done)
         begin
            adc_data <= adc_result;
         end
         if (adc_start)
         begin
            conv_busy <= 1'b1;
         end
         else if (adc_done)
         begin
            conv_busy <= 1'b0;
         end
         if (wr_done && !got_ctrl)
         begin
            adc_channel <= ch_clamp;                                         // RULE8
         end
         else if (adc_done && auto_inc)
         begin
            adc_channel <= ch_next;                                          // RULE7
         end
      end
   end

   // Output enable follows bit 6; the oscillator runs while it is set or a
   // conversion is pending, and is only driven out when it is the clock source.
   assign adc_config        = cfg_cur;                                       // RULE5
   assign analog_out_enable = aoe;                                           // RULE15
   assign osc_enable        = aoe | conv_busy;                               // RULE10
   assign osc_out_enable    = osc_enable & ~clock_source_select;

   // Open drain: pull low only, enable is active low.
   assign link.dev_sda_oe_n = ~sda_low;
   assign link.dev_sda_out  = 1'b0;
endmodule
`default_nettype wire

// [core/adf_host_end.sv]
// Bus master end: byte-level two-wire master driven from a small register port.
`timescale 1ns/100ps
`default_nettype none
module adf_host_end
   import adf_pkg::*;
#(
   parameter logic [7:0] QTR_CYC = adf_pkg::ADF_QTR_CYC
) (
   input  wire logic                           clk_sys,
   input  wire logic                           reset,
   input  wire logic                           clk_en,
   input  wire logic [1:0]                     reg_addr,
   input  wire logic [adf_pkg::ADF_BYTE_W-1:0] reg_wdata,
   input  wire logic                           reg_wr,
   input  wire logic                           reg_rd,
   output logic      [adf_pkg::ADF_BYTE_W-1:0] reg_rdata,
   adf_link_if.host                            link
);
   import adf_pkg::*;

   adf_host_state_t state;
   logic [7:0]      qcnt;
   logic [1:0]      phase;
   logic [3:0]      bit_cnt;
   logic [7:0]      txd;
   logic [7:0]      tx_sh;
   logic [7:0]      rx_sh;
   logic [7:0]      rx_data;
   logic            stop_q;
   logic            read_q;
   logic            nack_q;
   logic            ack_ok;
   logic            scl_low;
   logic            sda_low;
   logic            sda_s;

   adf_sync #(
      .WIDTH (1)
   ) u_sync (
      .clk_sys (clk_sys),
      .reset   (reset),
      .clk_en  (clk_en),
      .din     (link.sda),
      .dout    (sda_s)
   );

   // Command decode and control byte shaping.
   wire logic       busy    = (state != ADF_H_IDLE);
   wire logic       launch  = reg_wr & (reg_addr == ADF_REG_CMD) & ~busy;
   wire logic       tick    = (qcnt == QTR_CYC - 8'h01);
   wire logic       last    = (bit_cnt == ADF_LAST_BIT);
   wire logic [7:0] shaped  = (txd & ~ADF_RSVD_MASK)                          // RULE13
                              | (txd[ADF_AUTO_BIT] ? 8'h40 : 8'h00);          // RULE11
   wire logic [7:0] tx_load = reg_wdata[ADF_CMD_CTRL] ? shaped : txd;         // RULE12
   wire logic [7:0] stat    = {6'h00, ack_ok, busy};
   wire logic [7:0] rd_mux  = (reg_addr == ADF_REG_TXD)  ? txd :
                              (reg_addr == ADF_REG_RXD)  ? rx_data :
                              (reg_addr == ADF_REG_STAT) ? stat : 8'h00;

   // Register port; read data stands only in the cycle after the strobe.
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         txd       <= 8'h00;
         reg_rdata <= 8'h00;
      end
      else if (clk_en)
      begin
         reg_rdata <= reg_rd ? rd_mux : 8'h00;
         if (reg_wr && reg_addr == ADF_REG_TXD)
         begin
            txd <= reg_wdata;
         end
      end
   end

   // Bit engine: four quarter phases per bit, fall, set data, rise, sample.
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         state <= ADF_H_IDLE;
         qcnt  <= 8'h00;
         phase <= 2'h0;
         bit_cnt <= 4'h0;
         {tx_sh, rx_sh, rx_data} <= 24'h000000;
         {stop_q, read_q, nack_q, ack_ok} <= 4'h0;
         scl_low <= 1'b0;
         sda_low <= 1'b0;
      end
      else if (clk_en)
      begin
         qcnt <= (tick || !busy) ? 8'h00 : qcnt + 8'h01;
         if (launch)
         begin
            state   <= reg_wdata[ADF_CMD_START] ? ADF_H_START : ADF_H_BITS;
            phase   <= 2'h0;
            bit_cnt <= 4'h0;
            tx_sh   <= tx_load;
            // The byte after a start is always the address, sent as a write.
            read_q  <= reg_wdata[ADF_CMD_READ] & ~reg_wdata[ADF_CMD_START];  // RULE1
            stop_q  <= reg_wdata[ADF_CMD_STOP];                              // RULE21
            nack_q  <= reg_wdata[ADF_CMD_NACK];
         end
         else if (busy && tick)
         begin
            phase <= phase + 2'h1;
            case (state)
               ADF_H_START:
               begin
                  case (phase)
                     2'h0: scl_low <= 1'b1;
                     2'h1: sda_low <= 1'b0;
                     2'h2: scl_low <= 1'b0;
                     default:
                     begin
                        sda_low <= 1'b1;
                        state   <= ADF_H_BITS;
                     end
                  endcase
               end
               ADF_H_BITS:
               begin
                  case (phase)
                     2'h0: scl_low <= 1'b1;
                     2'h1: sda_low <= last ? (read_q & ~nack_q) : (~read_q & ~tx_sh[7]);
                     2'h2: scl_low <= 1'b0;
                     default:
                     begin
                        bit_cnt <= last ? 4'h0 : bit_cnt + 4'h1;
                        rx_sh   <= last ? rx_sh : {rx_sh[6:0], sda_s};
                        tx_sh   <= {tx_sh[6:0], 1'b0};
                        ack_ok  <= last ? ~sda_s : ack_ok;
                        rx_data <= (last && read_q) ? rx_sh : rx_data;
                        if (last)
                        begin
                           state <= stop_q ? ADF_H_STOP : ADF_H_IDLE;
                        end
                     end
                  endcase
               end
               ADF_H_STOP:
               begin
                  case (phase)
                     2'h0: scl_low <= 1'b1;
                     2'h1: sda_low <= 1'b1;
                     2'h2: scl_low <= 1'b0;
                     default:
                     begin
                        sda_low <= 1'b0;
                        state   <= ADF_H_IDLE;
                     end
                  endcase
               end
               default: state <= ADF_H_IDLE;
            endcase
         end
      end
   end

   // Open drain: lines are only ever pulled low, enables are active low.
   assign link.host_scl_oe_n = ~scl_low;
   assign link.host_scl_out  = 1'b0;
   assign link.host_sda_oe_n = ~sda_low;
   assign link.host_sda_out  = 1'b0;
endmodule
`default_nettype wire

// [bench/adf_link_checker.sv]
// Timing checks on the two-wire link between the master end and the device end.
`timescale 1ns/100ps
`default_nettype none
module adf_link_checker (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic host_scl_oe_n,
   input wire logic host_sda_oe_n,
   input wire logic dev_sda_oe_n,
   input wire logic scl,
   input wire logic sda
);
   // One clock domain, so clocking and reset are given once.
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   rel_lines_a: assert property ($fell(reset) |-> host_scl_oe_n && host_sda_oe_n && dev_sda_oe_n)
      else $error("link lines not released after reset");
   dev_low_a: assert property ($changed(dev_sda_oe_n) |-> !scl)
      else $error("device moved data while clock high");
   dev_late_a: assert property ($changed(dev_sda_oe_n) |-> !$past(scl, 2))
      else $error("device moved data too soon after clock fall");
   ack_hold_a: assert property ($fell(dev_sda_oe_n) |-> (!dev_sda_oe_n) [*7])
      else $error("device low bit shorter than a bit period");
   start_free_a: assert property ($fell(sda) && scl |-> dev_sda_oe_n)
      else $error("device driving data at a start");
   stop_free_a: assert property ($rose(sda) && scl |-> dev_sda_oe_n)
      else $error("device driving data at a stop");
   scl_high_a: assert property ($rose(scl) |-> scl [*4])
      else $error("clock high phase too short");
   scl_low_a: assert property ($fell(scl) |-> (!scl) [*4])
      else $error("clock low phase too short");
endmodule
`default_nettype wire

// [bench/tb.sv]
// Self-checking bench joining the master end and the device end over the link.
`timescale 1ns/100ps
`default_nettype none
module tb;
   import adf_pkg::*;
   logic       clk_sys;
   logic       reset;
   logic [1:0] reg_addr;
   logic [7:0] reg_wdata;
   logic       reg_wr;
   logic       reg_rd;
   logic [7:0] reg_rdata;
   logic [2:0] strap;
   logic [7:0] function_control;
   logic [7:0] dac_code;
   logic       analog_out_enable;
   logic       osc_enable;
   logic       osc_out_enable;
   logic       adc_start;
   logic       adc_done;
   logic [1:0] adc_channel;
   logic [1:0] adc_config;
   logic [7:0] s;
   logic [7:0] wa;
   int         num_errors;
   int         cmp_count;
   int         starts;

   adf_link_if adf_link_if_i ();
   adf_host_end adf_host_end_i (.clk_sys, .reset, .clk_en(1'h1), .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_rdata, .link(adf_link_if_i));
   adf_dev_end adf_dev_end_i (.clk_sys, .reset, .clk_en(1'h1), .link(adf_link_if_i),
      .addr_strap_0(strap[0]), .addr_strap_1(strap[1]), .addr_strap_2(strap[2]),
      .clock_source_select(1'h0), .adc_result(8'h5A), .adc_done, .function_control,
      .dac_code, .analog_out_enable, .osc_enable, .osc_out_enable, .adc_start,
      .adc_channel, .adc_config);
   adf_link_checker adf_link_checker_i (.clk_sys, .reset,
      .host_scl_oe_n(adf_link_if_i.host_scl_oe_n), .host_sda_oe_n(adf_link_if_i.host_sda_oe_n),
      .dev_sda_oe_n(adf_link_if_i.dev_sda_oe_n), .scl(adf_link_if_i.scl), .sda(adf_link_if_i.sda));

   // Free-running system clock.
   initial
   begin
      clk_sys = 1'h0;
      forever #50 clk_sys = ~clk_sys;
   end

   // Converter stand-in answers each start one cycle later and counts starts.
   always @(posedge clk_sys)
   begin
      adc_done <= adc_start;
      starts <= reset ? 0 : starts + int'(adc_start === 1'h1);
   end

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
      cmp_count++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Each access leaves a gap edge so a strobe is never set and cleared in one step.
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge clk_sys);
      reg_wr <= 1'h0;
   endtask

   task automatic rd(input logic [1:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge clk_sys);
      reg_rd <= 1'h0;
      #1 d = reg_rdata;
   endtask

   // One byte on the link; the status poll is bounded so a stuck engine cannot hang.
   task automatic xfer(input logic [7:0] c, input logic [7:0] t, output logic [7:0] st);
      wr(ADF_REG_TXD, t);
      wr(ADF_REG_CMD, c);
      st = 8'h01;
      for (int i = 0; i < 400 && st[ADF_STAT_BUSY] !== 1'h0; i++)
         rd(ADF_REG_STAT, st);
      // A poll that runs out means a stuck engine and counts as a mismatch.
      if (st[ADF_STAT_BUSY] !== 1'h0)
         num_errors++;
   endtask

   task automatic summarize;
      $display("mismatches %0d of %0d compares", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // Command codes: 01 start, 02 stop, 04 read, 08 master nack, 10 control shaping.
   initial
   begin
      reset = 1'h1;
      reg_addr = 2'h0;
      reg_wdata = 8'h00;
      reg_wr = 1'h0;
      reg_rd = 1'h0;
      strap = 3'h5;
      wa = {ADF_FIXED_ADDR_DEF, 3'h5, 1'h0};
      repeat (4) @(posedge clk_sys);
      reset <= 1'h0;
      repeat (4) @(posedge clk_sys);
      chk(function_control, 8'h00, "ctrl");
      chk({6'h00, osc_enable, analog_out_enable}, 8'h00, "off");
      xfer(8'h03, wa ^ 8'h04, s);
      chk({7'h00, s[ADF_STAT_ACK]}, 8'h00, "ack wrong");
      xfer(8'h01, wa, s);
      chk({7'h00, s[ADF_STAT_ACK]}, 8'h01, "ack");
      xfer(8'h00, 8'h45, s);
      xfer(8'h02, 8'h3C, s);
      chk(function_control, 8'h45, "ctrl");
      chk({6'h00, analog_out_enable, osc_out_enable}, 8'h03, "aoe");
      chk({adc_config, 4'h0, adc_channel}, 8'h01, "fields");
      chk(dac_code, 8'h3C, "dac");
      xfer(8'h03, wa, s);
      chk(function_control, 8'h45, "ctrl");
      for (int k = 0; k < 4; k++)
      begin
         xfer(8'h01, wa, s);
         xfer(8'h02, 8'(k * 16 + 3), s);
         chk({adc_config, 4'h0, adc_channel}, {k[1:0], 4'h0, ADF_MAX_CH_TABLE[2*k +: 2]}, "clamp");
      end
      chk(dac_code, 8'h3C, "dac");
      xfer(8'h01, wa, s);
      xfer(8'h12, 8'hBF, s);
      chk(function_control, 8'h77, "shape");
      rd(ADF_REG_TXD, s);
      chk(s, 8'hBF, "txd");
      for (int n = 0; n < 2; n++)
      begin
         xfer(8'h01, wa | 8'h01, s);
         xfer(8'h0E, 8'h00, s);
         rd(ADF_REG_RXD, s);
         chk(s, n == 0 ? ADF_ADC_RESET : 8'h5A, "rxd");
         chk({6'h00, adc_channel}, 8'(n), "auto");
      end
      chk(8'(starts), 8'h02, "starts");
      @(posedge clk_sys);
      reset <= 1'h1;
      repeat (2) @(posedge clk_sys);
      reset <= 1'h0;
      @(posedge clk_sys);
      #1 chk(function_control, 8'h00, "ctrl");
      chk({6'h00, osc_enable, analog_out_enable}, 8'h00, "off");
      summarize();
   end

   // Watchdog sized well beyond the roughly 1700 cycles the sequence needs.
   initial
   begin
      #5000000;
      num_errors++;
      summarize();
   end
endmodule
`default_nettype wire
